// ---- rtl/usc_defs.svh ----
// Offsets, field positions, reset values and timing counts of the serial status block
`ifndef USC_DEFS_SVH
`define USC_DEFS_SVH

`define USC_OFS_STA       4'h0
`define USC_OFS_TXDATA    4'h1
`define USC_OFS_RXDATA    4'h2
`define USC_OFS_MODE      4'h3
`define USC_OFS_BAUD      4'h4

`define USC_B_TXISEL1     15
`define USC_B_TXINV       14
`define USC_B_TXISEL0     13
`define USC_B_BRK         11
`define USC_B_TXEN        10
`define USC_B_TXFULL      9
`define USC_B_TXEMPTY     8
`define USC_B_RXISEL1     7
`define USC_B_RXISEL0     6
`define USC_B_ADDRESS_DETECT_ENABLE       5
`define USC_B_RECEIVER_IDLE_FLAG       4
`define USC_B_PARITY_ERROR_FLAG        3
`define USC_B_FRAMING_ERROR_FLAG        2
`define USC_B_OVERRUN_FLAG        1
`define USC_B_RXDA        0

`define USC_B_INFRARED_CODEC_ENABLE        3
`define USC_B_FMT1        2
`define USC_B_FMT0        1
`define USC_B_STOP2       0

`define USC_BAUD_RST      16'h0006
`define USC_FIFO_DEPTH    4
`define USC_BRK_ZEROS     12

`endif

// ---- rtl/usc_pkg.sv ----
// Types of the serial status and control block
package usc_pkg;
  typedef enum logic [1:0] {
    USC_TX_IDLE  = 2'b00,
    USC_TX_SHIFT = 2'b01,
    USC_TX_STOP  = 2'b11
  } usc_tx_st_t;

  typedef enum logic [1:0] {
    USC_RX_IDLE  = 2'b00,
    USC_RX_DATA  = 2'b01,
    USC_RX_STOP  = 2'b11
  } usc_rx_st_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } usc_bus_t;

  typedef struct packed {
    logic [8:0] data;
    logic       parity_error_flag;
    logic       framing_error_flag;
  } usc_rx_ent_t;
endpackage

// ---- rtl/usc_uart.sv ----
// Serial transceiver with status/control register, 4-deep FIFOs
//
// How it works
// - Tx select 10: interrupt when a load into shifter empties transmit buffer.
// - Tx select 01: interrupt when last character fully shifted out.
// - Tx select 00: interrupt on every load into shifter; 11 unused.
// - Infrared off: polarity bit set makes line idle low.
// - Infrared on: polarity sense reverses for encoded idle level.
// - Break: start bit, twelve zeros, stop bit; then bit self-clears.
// - Clearing enable aborts transmit, flushes buffer, releases pin to port.
// - Full flag reads one while transmit buffer has no free slot.
// - Empty flag one only when shifter and buffer both empty.
// - Rx select 11: interrupt when transfer makes four buffered.
// - Rx select 10: interrupt when transfer leaves three buffered.
// - Rx select 0x: interrupt on every transfer into buffer.
// - Address detect keeps only ninth-bit-set characters, in 9-bit format.
// - Receiver idle flag resets to one, zero while receiving.
// - Parity error flag belongs to the character at FIFO head.
// - Framing error flag belongs to the character at FIFO head.
// - Overrun set on overflow; software clear flushes buffer and shifter.
// - Data available while receive buffer holds a character.
// - Transmit and receive buffers are four-deep FIFOs.
// - Data format 11 selects 9-bit data without parity.
`timescale 1ns/10ps
`include "usc_defs.svh"

module usc_uart
  import usc_pkg::*;
#(
  parameter int DEPTH = `USC_FIFO_DEPTH
) (
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_rx,
  output logic      [15:0] o_rdata,
  output logic             o_tx,
  output logic             o_tx_oe_n,
  output logic             o_tx_irq,
  output logic             o_rx_irq
);
  import usc_pkg::*;

  // Pointers and counters are sized for four entries only
  if (DEPTH != 4) begin : g_depth_chk
    $error("usc_uart: DEPTH must be 4");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0]     rdata;
    logic [1:0]      txisel;
    logic            txinv;
    logic            brk;
    logic            txen;
    logic [1:0]      rxisel;
    logic            address_detect_enable;
    logic            overrun_flag;
    logic            infrared_codec_enable;
    logic [1:0]      fmt;
    logic            stop2;
    logic [15:0]     baud;
    logic [3:0][8:0] txf;
    logic [1:0]      txwp;
    logic [1:0]      txrp;
    logic [2:0]      txcnt;
    usc_tx_st_t      txst;
    logic [15:0]     txdiv;
    logic [13:0]     txsh;
    logic [3:0]      txbits;
    logic            stopn;
    logic            txbrk;
    logic            txline;
    logic            txoe_n;
    logic            txirq;
    logic [3:0][10:0] rxf;
    logic [1:0]      rxwp;
    logic [1:0]      rxrp;
    logic [2:0]      rxcnt;
    usc_rx_st_t      rxst;
    logic [15:0]     rxdiv;
    logic [8:0]      rxsh;
    logic [3:0]      rxbits;
    logic            rxpar;
    logic            rxirq;
  } usc_st_t;

  usc_st_t s_q;
  usc_st_t s_d;

  function automatic logic [15:0] half_of(input logic [15:0] b);
    half_of = {1'b0, b[15:1]};
  endfunction

  function automatic logic [3:0] nbits(input logic [1:0] f);
    nbits = (f == 2'b11) ? 4'd9 : ((f == 2'b00) ? 4'd8 : 4'd9);
  endfunction

  usc_bus_t bus;
  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  logic nine_bit;
  logic par_on;
  logic w_sta;
  logic w_tx;
  logic r_rx;
  logic rx_flush;
  logic [15:0] sta;
  logic [10:0] head;
  usc_rx_ent_t ent;
  logic [8:0]  ch;
  logic        keep;
  logic        last;

  always_comb begin
    nine_bit = (s_q.fmt == 2'b11);
    par_on   = (s_q.fmt == 2'b01) || (s_q.fmt == 2'b10);
    w_sta    = bus.wr && (bus.addr == `USC_OFS_STA);
    w_tx     = bus.wr && (bus.addr == `USC_OFS_TXDATA);
    r_rx     = bus.rd && (bus.addr == `USC_OFS_RXDATA) && (s_q.rxcnt != 3'd0);
    rx_flush = w_sta && s_q.overrun_flag && !bus.wdata[`USC_B_OVERRUN_FLAG];
    head     = s_q.rxf[s_q.rxrp];
    sta      = 16'h0000;
    sta[`USC_B_TXISEL1] = s_q.txisel[1];
    sta[`USC_B_TXINV]   = s_q.txinv;
    sta[`USC_B_TXISEL0] = s_q.txisel[0];
    sta[`USC_B_BRK]     = s_q.brk;
    sta[`USC_B_TXEN]    = s_q.txen;
    sta[`USC_B_TXFULL]  = (s_q.txcnt == 3'd4);
    sta[`USC_B_TXEMPTY] = (s_q.txcnt == 3'd0) && (s_q.txst == USC_TX_IDLE);
    sta[`USC_B_RXISEL1] = s_q.rxisel[1];
    sta[`USC_B_RXISEL0] = s_q.rxisel[0];
    sta[`USC_B_ADDRESS_DETECT_ENABLE]   = s_q.address_detect_enable;
    sta[`USC_B_RECEIVER_IDLE_FLAG]   = (s_q.rxst == USC_RX_IDLE);
    sta[`USC_B_PARITY_ERROR_FLAG]    = (s_q.rxcnt != 3'd0) && head[1];
    sta[`USC_B_FRAMING_ERROR_FLAG]    = (s_q.rxcnt != 3'd0) && head[0];
    sta[`USC_B_OVERRUN_FLAG]    = s_q.overrun_flag;
    sta[`USC_B_RXDA]    = (s_q.rxcnt != 3'd0);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d       = s_q;
    s_d.txirq = 1'b0;
    s_d.rxirq = 1'b0;
    ent       = '0;
    ch        = '0;
    keep      = 1'b0;
    last      = 1'b0;

    // Register reads, data one cycle later
    unique case (bus.addr)
      `USC_OFS_STA:    s_d.rdata = sta;
      `USC_OFS_RXDATA: s_d.rdata = {7'h00, head[10:2]};
      `USC_OFS_MODE:   s_d.rdata = {12'h000, s_q.infrared_codec_enable, s_q.fmt, s_q.stop2};
      `USC_OFS_BAUD:   s_d.rdata = s_q.baud;
      default:         s_d.rdata = 16'h0000;
    endcase
    if (!bus.rd) s_d.rdata = 16'h0000;

    if (w_sta) begin
      s_d.txisel = {bus.wdata[`USC_B_TXISEL1], bus.wdata[`USC_B_TXISEL0]};
      s_d.txinv  = bus.wdata[`USC_B_TXINV];
      s_d.brk    = s_q.brk | bus.wdata[`USC_B_BRK];
      s_d.txen   = bus.wdata[`USC_B_TXEN];
      s_d.rxisel = bus.wdata[`USC_B_RXISEL1:`USC_B_RXISEL0];
      s_d.address_detect_enable  = bus.wdata[`USC_B_ADDRESS_DETECT_ENABLE];
    end
    if (bus.wr && bus.addr == `USC_OFS_MODE) begin
      s_d.infrared_codec_enable  = bus.wdata[`USC_B_INFRARED_CODEC_ENABLE];
      s_d.fmt   = bus.wdata[`USC_B_FMT1:`USC_B_FMT0];
      s_d.stop2 = bus.wdata[`USC_B_STOP2];
    end
    if (bus.wr && bus.addr == `USC_OFS_BAUD) s_d.baud = bus.wdata;

    // Transmit FIFO write; full buffer drops the word
    if (w_tx && s_q.txen && s_q.txcnt != 3'd4) begin
      s_d.txf[s_q.txwp] = bus.wdata[8:0];
      s_d.txwp  = s_q.txwp + 2'd1;
      s_d.txcnt = s_d.txcnt + 3'd1;
    end

    // Transmitter
    unique case (s_q.txst)
      USC_TX_IDLE: begin
        if (s_q.txcnt != 3'd0) begin
          s_d.txrp  = s_q.txrp + 2'd1;
          s_d.txcnt = s_d.txcnt - 3'd1;
          s_d.txdiv = s_q.baud;
          s_d.txst  = USC_TX_SHIFT;
          s_d.txline = 1'b0;
          s_d.txbrk  = s_q.brk;
          if (s_q.brk) begin
            s_d.txsh   = 14'h0000;
            s_d.txbits = 4'(`USC_BRK_ZEROS);
          end else begin
            s_d.txsh   = {4'h0, ^s_q.txf[s_q.txrp][7:0] ^ (s_q.fmt == 2'b10),
                          nine_bit ? s_q.txf[s_q.txrp] : {1'b0, s_q.txf[s_q.txrp][7:0]}};
            s_d.txbits = (nine_bit || par_on) ? 4'd9 : 4'd8;
            if (par_on) s_d.txsh[8] = ^s_q.txf[s_q.txrp][7:0] ^ (s_q.fmt == 2'b10);
          end
          // Load interrupts
          if (s_q.txisel == 2'b00) s_d.txirq = 1'b1;
          if (s_q.txisel == 2'b10 && s_d.txcnt == 3'd0) s_d.txirq = 1'b1;
        end
      end
      USC_TX_SHIFT: begin
        if (s_q.txdiv == 16'h0000) begin
          s_d.txdiv  = s_q.baud;
          s_d.txline = s_q.txsh[0];
          s_d.txsh   = {1'b0, s_q.txsh[13:1]};
          s_d.txbits = s_q.txbits - 4'd1;
          if (s_q.txbits == 4'd0) begin
            s_d.txline = 1'b1;
            s_d.stopn  = s_q.stop2;
            s_d.txst   = USC_TX_STOP;
          end
        end else begin
          s_d.txdiv = s_q.txdiv - 16'h0001;
        end
      end
      USC_TX_STOP: begin
        if (s_q.txdiv == 16'h0000) begin
          s_d.txdiv = s_q.baud;
          if (s_q.stopn) begin
            s_d.stopn = 1'b0;
          end else begin
            s_d.txst = USC_TX_IDLE;
            // Only a finished break frame clears it; a new request wins
            if (s_q.txbrk) s_d.brk = w_sta && bus.wdata[`USC_B_BRK];
            last = (s_q.txcnt == 3'd0);
            if (s_q.txisel == 2'b01 && last) s_d.txirq = 1'b1;
          end
        end else begin
          s_d.txdiv = s_q.txdiv - 16'h0001;
        end
      end
      default: s_d.txst = USC_TX_IDLE;
    endcase

    // Disable aborts and flushes; pin goes back to port
    if (!s_d.txen) begin
      s_d.txst   = USC_TX_IDLE;
      s_d.txcnt  = 3'd0;
      s_d.txwp   = 2'd0;
      s_d.txrp   = 2'd0;
      s_d.txline = 1'b1;
    end
    s_d.txoe_n = ~s_d.txen;

    // Receiver, mid-bit sampling
    unique case (s_q.rxst)
      USC_RX_IDLE: begin
        if (!i_rx) begin
          s_d.rxdiv  = half_of(s_q.baud);
          s_d.rxbits = nbits(s_q.fmt);
          s_d.rxst   = USC_RX_DATA;
          s_d.rxsh   = '0;
          s_d.rxpar  = 1'b0;
        end
      end
      USC_RX_DATA: begin
        if (s_q.rxdiv == 16'h0000) begin
          s_d.rxdiv = s_q.baud;
          if (s_q.rxbits == nbits(s_q.fmt) && s_q.rxsh == '0 && s_q.rxpar == 1'b0) begin
            s_d.rxpar = 1'b1;
            if (i_rx) s_d.rxst = USC_RX_IDLE;
          end else begin
            s_d.rxsh   = {i_rx, s_q.rxsh[8:1]};
            s_d.rxbits = s_q.rxbits - 4'd1;
            if (s_q.rxbits == 4'd1) s_d.rxst = USC_RX_STOP;
          end
        end else begin
          s_d.rxdiv = s_q.rxdiv - 16'h0001;
        end
      end
      USC_RX_STOP: begin
        if (s_q.rxdiv == 16'h0000) begin
          s_d.rxst  = USC_RX_IDLE;
          s_d.rxpar = 1'b0;
          ch = nine_bit ? s_q.rxsh : {1'b0, s_q.rxsh[8:1]};
          if (s_q.fmt == 2'b00) ch = {1'b0, s_q.rxsh[8:1]};
          ent.data = par_on ? {1'b0, s_q.rxsh[7:0]} : ch;
          ent.parity_error_flag = par_on && ((^s_q.rxsh) != (s_q.fmt == 2'b10));
          ent.framing_error_flag = !i_rx;
          keep = !(s_q.address_detect_enable && nine_bit && !ent.data[8]);
          if (keep && s_q.overrun_flag) begin
            keep = 1'b0;
          end else if (keep && s_q.rxcnt == 3'd4 && !r_rx) begin
            keep = 1'b0;
            s_d.overrun_flag = 1'b1;
          end
          if (keep) begin
            s_d.rxf[s_q.rxwp] = {ent.data, ent.parity_error_flag, ent.framing_error_flag};
            s_d.rxwp = s_q.rxwp + 2'd1;
            unique case (s_q.rxisel)
              2'b11:   s_d.rxirq = ((s_q.rxcnt - {2'b00, r_rx}) == 3'd3);
              2'b10:   s_d.rxirq = ((s_q.rxcnt - {2'b00, r_rx}) == 3'd2);
              default: s_d.rxirq = 1'b1;
            endcase
          end
        end else begin
          s_d.rxdiv = s_q.rxdiv - 16'h0001;
        end
      end
      default: s_d.rxst = USC_RX_IDLE;
    endcase

    if (r_rx) s_d.rxrp = s_q.rxrp + 2'd1;
    s_d.rxcnt = s_q.rxcnt + {2'b00, keep} - {2'b00, r_rx};
    // Overrun can only be cleared; flush last so no receiver step undoes it
    if (rx_flush) begin
      s_d.overrun_flag  = 1'b0;
      s_d.rxcnt = 3'd0;
      s_d.rxwp  = 2'd0;
      s_d.rxrp  = 2'd0;
      s_d.rxsh  = '0;
      s_d.rxst  = USC_RX_IDLE;
      s_d.rxpar = 1'b0;
      s_d.rxirq = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q        <= '0;
      s_q.baud   <= `USC_BAUD_RST;
      s_q.txline <= 1'b1;
      s_q.txoe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Polarity after infrared sense reversal; encoder itself lives elsewhere
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_tx <= 1'b1;
    end else begin
      o_tx <= s_d.txline ^ (s_d.txinv ^ s_d.infrared_codec_enable);
    end
  end

  assign o_rdata   = s_q.rdata;
  assign o_tx_oe_n = s_q.txoe_n;
  assign o_tx_irq  = s_q.txirq;
  assign o_rx_irq  = s_q.rxirq;
endmodule

// ---- dv/usc_uart_sva.sv ----
// Port checker for the serial status and control block
`timescale 1ns/10ps
module usc_uart_sva (
  input wire logic        i_mclk,
  input wire logic        i_arst_n,
  input wire logic [3:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic        o_tx_oe_n,
  input wire logic        o_tx_irq,
  input wire logic        o_rx_irq
);
  // ---
  // Properties
  // ---
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  unmapped_read_a: assert property (i_rd && i_addr > 4'h4 |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
  tx_flags_a: assert property (i_rd && i_addr == 4'h0 |=> !(o_rdata[9] && o_rdata[8]))
    else $error("full and empty together");
  reserved_bit_a: assert property (i_rd && i_addr == 4'h0 |=> !o_rdata[12])
    else $error("unused status bit set");
  oe_on_a: assert property (i_wr && i_addr == 4'h0 && i_wdata[10] |=> !o_tx_oe_n)
    else $error("pin not taken");
  oe_off_a: assert property (i_wr && i_addr == 4'h0 && !i_wdata[10] |=> o_tx_oe_n)
    else $error("pin not released");
  oe_cause_a: assert property ($fell(o_tx_oe_n) |->
    $past(i_wr) && $past(i_addr) == 4'h0 && $past(i_wdata[10]))
    else $error("pin taken without write");
  tx_irq_pulse_a: assert property (o_tx_irq |=> !o_tx_irq)
    else $error("tx irq too long");
  rx_irq_pulse_a: assert property (o_rx_irq |=> !o_rx_irq)
    else $error("rx irq too long");
endmodule

bind usc_uart usc_uart_sva u_sva (.i_mclk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .o_tx_oe_n, .o_tx_irq, .o_rx_irq);

// ---- dv/usc_line_model.sv ----
// Remote serial device on the line
`timescale 1ns/10ps
module usc_line_model #(
  parameter int BIT = 7
) (
  input  wire logic i_mclk,
  input  wire logic i_line,
  output logic      o_line,
  output int        o_low
);
  int run;
  initial begin
    o_line = 1'b1;
    run    = 0;
    o_low  = 0;
  end
  // Last low stretch on our input, in clocks
  always @(posedge i_mclk) begin
    if (!i_line) begin
      run <= run + 1;
    end else begin
      if (run != 0) o_low <= run;
      run <= 0;
    end
  end
  // Start, n bits LSB first, stop level; idles high as a released line
  task automatic send(input logic [8:0] d, input int n, input logic stp);
    o_line <= 1'b0;
    repeat (BIT) @(posedge i_mclk);
    for (int i = 0; i < n; i++) begin
      o_line <= d[i];
      repeat (BIT) @(posedge i_mclk);
    end
    o_line <= stp;
    repeat (BIT) @(posedge i_mclk);
    o_line <= 1'b1;
    repeat (2 * BIT) @(posedge i_mclk);
  endtask
endmodule

// ---- dv/test_uart_status_control.sv ----
// Self-checking bench for the serial status and control block
`timescale 1ns/10ps
module test_uart_status_control;
  import usc_pkg::*;
  localparam int BIT = 7;
  logic        i_mclk, i_arst_n, i_wr, i_rd, rx, o_tx, o_tx_oe_n, o_tx_irq, o_rx_irq;
  logic [3:0]  i_addr;
  logic [15:0] i_wdata, o_rdata, rv;
  int          low, num_errors, tests_run, ntx, nrx, cyc, t0, t1;

  usc_uart dut (.i_mclk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .i_rx(rx),
    .o_rdata, .o_tx, .o_tx_oe_n, .o_tx_irq, .o_rx_irq);
  usc_line_model #(.BIT(BIT)) m (.i_mclk, .i_line(o_tx), .o_line(rx), .o_low(low));

  // ---
  // Tasks
  // ---
  task automatic close_out();
    if (num_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One idle cycle after each strobe, so a strobe is never re-raised in its own step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic rd(input logic [3:0] a);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
    @(posedge i_mclk);
  endtask
  task automatic st(input logic [15:0] e);
    rd(4'h0);
    chk("status", e, rv);
  endtask
  task automatic drain();
    rv = 16'h0000;
    for (int k = 0; k < 400 && rv[8] !== 1'b1; k++) rd(4'h0);
  endtask

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc++;
    if (o_tx_irq) begin
      ntx++;
      t1 = cyc;
    end
    if (o_rx_irq) nrx++;
    if (cyc > 20000) begin
      num_errors++;
      close_out();
    end
  end

  // ---
  // Sequence
  // ---
  initial begin
    {i_arst_n, i_wr, i_rd, i_addr, i_wdata} = '0;
    repeat (3) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    @(posedge i_mclk);
    st(16'h0110);
    rd(4'hF);
    chk("unmapped", 16'h0000, rv);
    wr(4'h0, 16'h03FF);
    st(16'h01F0);
    wr(4'h0, 16'h0400);
    chk("oe_n", 16'h0000, 16'(o_tx_oe_n));
    ntx = 0;
    for (int i = 0; i < 6; i++) wr(4'h1, 16'h00F0);
    st(16'h0610);
    drain();
    chk("tx irqs", 16'd5, 16'(ntx));
    chk("status", 16'h0510, rv);
    chk("low run", 16'(5 * BIT), 16'(low));
    for (int s = 0; s < 3; s++) begin // reserved select 11 never written
      wr(4'h0, 16'h0400 | 16'(s[1]) << 15 | 16'(s[0]) << 13);
      ntx = 0;
      t0 = cyc;
      wr(4'h1, 16'h00F0);
      drain();
      chk("tx irq", 16'd1, 16'(ntx));
      chk("tx irq late", 16'(s == 1), 16'(t1 - t0 > 9 * BIT));
    end
    wr(4'h0, 16'h0C00);
    wr(4'h1, 16'h0055);
    drain();
    chk("break run", 16'(13 * BIT), 16'(low));
    chk("status", 16'h0510, rv);
    wr(4'h1, 16'h0001);
    wr(4'h1, 16'h0002);
    wr(4'h0, 16'h4000);
    st(16'h4110);
    chk("oe_n", 16'h0001, 16'(o_tx_oe_n));
    chk("tx idle", 16'h0000, 16'(o_tx));
    wr(4'h3, 16'h0008);
    @(posedge i_mclk);
    chk("tx idle", 16'h0001, 16'(o_tx));
    wr(4'h3, 16'h0002);
    wr(4'h0, 16'h0000);
    nrx = 0;
    m.send(9'h001, 9, 1'b1);
    m.send(9'h003, 9, 1'b1);
    m.send(9'h104, 9, 1'b0);
    chk("rx irqs", 16'd3, 16'(nrx));
    st(16'h0119);
    rd(4'h2);
    chk("rx data", 16'h0001, rv);
    st(16'h0111);
    rd(4'h2);
    chk("rx data", 16'h0003, rv);
    st(16'h0115);
    rd(4'h2);
    st(16'h0110);
    wr(4'h3, 16'h0000);
    wr(4'h0, 16'h0080);
    nrx = 0;
    for (int i = 1; i < 4; i++) m.send(9'(i), 8, 1'b1);
    chk("rx irqs", 16'd1, 16'(nrx));
    wr(4'h0, 16'h00C0);
    for (int i = 4; i < 6; i++) m.send(9'(i), 8, 1'b1);
    chk("rx irqs", 16'd2, 16'(nrx));
    st(16'h01D3);
    rd(4'h2);
    chk("rx data", 16'h0001, rv);
    wr(4'h0, 16'h00C0);
    st(16'h01D0);
    wr(4'h3, 16'h0006);
    wr(4'h0, 16'h0020);
    m.send(9'h055, 9, 1'b1);
    m.send(9'h1AA, 9, 1'b1);
    rd(4'h2);
    chk("rx data", 16'h01AA, rv);
    st(16'h0130);
    wr(4'h3, 16'h0004);
    wr(4'h0, 16'h0000);
    m.send(9'h107, 9, 1'b1);
    st(16'h0119);
    close_out();
  end
endmodule
